// ==== hdl/dcc_sampler.sv ====
// samples one comparator output, waits out settling, reports edges
`timescale 1ns/1ns
`include "dcc_regs.svh"

module dcc_sampler #(
    parameter int unsigned SETTLE_CYCLES = `DCC_SETTLE_CYC
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             enable,
    input  wire logic             raw,
    output logic                  level,
    output logic                  settled,
    output dcc_pkg::dcc_edge_type edge_ev
);
    import dcc_pkg::*;

    localparam int unsigned    CW          = $clog2(SETTLE_CYCLES + 1);
    localparam logic [CW-1:0] SETTLE_LOAD = CW'(SETTLE_CYCLES);

    logic [CW-1:0] settle_cnt;
    logic          settled_d;

    // the analog output is junk until settled, so no edge may come from it
    wire logic cnt_done   = settle_cnt == '0;
    wire logic both_ok    = settled & settled_d;
    wire logic next_level = settled ? raw : 1'b0;
    assign settled      = enable & cnt_done;
    assign edge_ev.rise = both_ok & raw & ~level;
    assign edge_ev.fall = both_ok & ~raw & level;

    // settle counter reloads whenever the comparator is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= SETTLE_LOAD;
            level      <= 1'b0;
            settled_d  <= 1'b0;
        end else begin
            settle_cnt <= !enable ? SETTLE_LOAD : (cnt_done ? settle_cnt : settle_cnt - 1'b1);
            level      <= next_level;
            settled_d  <= settled;
        end
    end

    property p_off_zero;
        @(posedge pclk) disable iff (!presetn)
        !enable |=> !level;
    endproperty
    a_off_zero: assert property (p_off_zero) else $error("level high while disabled");

    property p_no_edge_off;
        @(posedge pclk) disable iff (!presetn)
        !enable |-> !edge_ev.rise && !edge_ev.fall;
    endproperty
    a_no_edge_off: assert property (p_no_edge_off) else $error("edge while disabled");

    property p_sample;
        @(posedge pclk) disable iff (!presetn)
        settled |=> level == $past(raw);
    endproperty
    a_sample: assert property (p_sample) else $error("level not sampled from raw");

    property p_settle_wait;
        @(posedge pclk) disable iff (!presetn)
        $rose(enable) |-> !settled ##1 !settled;
    endproperty
    a_settle_wait: assert property (p_settle_wait) else $error("settled too early");

endmodule

// ==== hdl/dcc_top.sv ====
// comparator control bank: apb registers, sampling, flags, triggers, interrupt
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "dcc_regs.svh"

// Summary of operation
// - control words at offsets 0x00 and 0x04
// - status 0x08, reference 0x0c, all but the mask word (0x10, reset 0x3) reset zero
// - bits 30:29 pick positive input pin
// - bit 9 enables falling edge trigger
// - bit 8 enables rising edge trigger
// - edge enables act only when trigger routed
// - bit 4 picks negative input source
// - bit 2 switches hysteresis on
// - bit 1 enables comparator interrupt
// - bit 0 switches comparator on
// - output sampled by clock into status
// - output change sets flag, raises interrupt
// - writing one clears flag, zero keeps
module dcc_top #(
    parameter int unsigned SETTLE_CYCLES = `DCC_SETTLE_CYC,
    parameter logic [31:0] REFV_MASK     = `DCC_REFV_MASK
) (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [1:0]                  comparator_raw,
    output dcc_pkg::dcc_ctrl_type [1:0]      comparator_cfg,
    output logic [31:0]                      reference_voltage_control,
    output logic [1:0]                       trigger_rise,
    output logic [1:0]                       trigger_fall,
    output logic                             comparator_irq
);
    import dcc_pkg::*;

    logic [1:0][31:0]    ctrl_word;
    logic [1:0]          irq_flag;
    logic [1:0]          irq_mask;
    logic [1:0]          trig_route;
    logic [1:0]          out_level;
    logic [1:0]          out_settled;
    dcc_edge_type [1:0]  edge_ev;
    logic [1:0]          out_change;
    logic [1:0]          flag_clear;
    logic [1:0]          next_irq_flag;
    logic [1:0]          next_trig_rise;
    logic [1:0]          next_trig_fall;
    logic [1:0]          irq_enable;
    logic [31:0]         rd_mux;

    // apb phase decode; the slave never inserts wait states
    wire logic setup_ph  = psel & ~penable;
    wire logic access_ph = psel & penable;
    wire logic wr_en     = access_ph & pwrite;
    assign pready = 1'b1;

    // address decode
    wire logic hit_ctrl0  = paddr == `DCC_OFF_CTRL0;
    wire logic hit_ctrl1  = paddr == `DCC_OFF_CTRL1;
    wire logic hit_status = paddr == `DCC_OFF_STATUS;
    wire logic hit_refv   = paddr == `DCC_OFF_REFV;
    wire logic hit_mask   = paddr == `DCC_OFF_IRQ_MASK;
    wire logic hit_route  = paddr == `DCC_OFF_TRIG_ROUTE;
    wire logic hit_any    = hit_ctrl0 | hit_ctrl1 | hit_status | hit_refv | hit_mask | hit_route;
    wire logic [1:0] hit_ctrl = {hit_ctrl1, hit_ctrl0};
    assign pslverr = access_ph & ~hit_any;

    // write-one-to-clear on status flags; output bits there are read only
    wire logic [1:0] w1c_bits = pwdata[`DCC_STAT_FLAG_LO +: 2];
    assign flag_clear = (wr_en & hit_status) ? w1c_bits : 2'h0;

    // per-comparator control, sampling, flag and trigger logic
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_cmp
            // only implemented bits are stored, so reserved ones stay zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_word[gi] <= `DCC_CTRL_RST;
                end else if (wr_en && hit_ctrl[gi]) begin
                    ctrl_word[gi] <= pwdata & `DCC_CTRL_MASK;
                end
            end

            // field unpacking toward the analog cell
            assign comparator_cfg[gi].positive_input_select =
                ctrl_word[gi][`DCC_POS_SEL_HI:`DCC_POS_SEL_LO];
            assign comparator_cfg[gi].falling_trigger_enable = ctrl_word[gi][`DCC_FALL_BIT];
            assign comparator_cfg[gi].rising_trigger_enable  = ctrl_word[gi][`DCC_RISE_BIT];
            assign comparator_cfg[gi].negative_source_select = ctrl_word[gi][`DCC_NEG_BIT];
            assign comparator_cfg[gi].hysteresis_enable      = ctrl_word[gi][`DCC_HYS_BIT];
            assign comparator_cfg[gi].comparator_irq_enable  = ctrl_word[gi][`DCC_IE_BIT];
            assign comparator_cfg[gi].comparator_enable      = ctrl_word[gi][`DCC_EN_BIT];
            assign irq_enable[gi] = comparator_cfg[gi].comparator_irq_enable;

            dcc_sampler #(
                .SETTLE_CYCLES (SETTLE_CYCLES)
            ) u_sampler (
                .pclk    (pclk),
                .presetn (presetn),
                .enable  (comparator_cfg[gi].comparator_enable),
                .raw     (comparator_raw[gi]),
                .level   (out_level[gi]),
                .settled (out_settled[gi]),
                .edge_ev (edge_ev[gi])
            );

            // a new change wins over a clear in the same cycle
            assign out_change[gi]    = edge_ev[gi].rise | edge_ev[gi].fall;
            assign next_irq_flag[gi] = (irq_flag[gi] & ~flag_clear[gi]) | out_change[gi];

            // edge enables only matter when this comparator drives pwm/timer
            assign next_trig_rise[gi] = edge_ev[gi].rise & comparator_cfg[gi].rising_trigger_enable
                                        & trig_route[gi];
            assign next_trig_fall[gi] = edge_ev[gi].fall
                                        & comparator_cfg[gi].falling_trigger_enable
                                        & trig_route[gi];
        end
    endgenerate

    // status flags and trigger pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_flag     <= `DCC_FLAG_RST;
            trigger_rise <= 2'h0;
            trigger_fall <= 2'h0;
        end else begin
            irq_flag     <= next_irq_flag;
            trigger_rise <= next_trig_rise;
            trigger_fall <= next_trig_fall;
        end
    end

    // reference, mask and trigger routing registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_voltage_control <= `DCC_REFV_RST;
            irq_mask                  <= `DCC_MASK_RST;
            trig_route                <= `DCC_ROUTE_RST;
        end else if (wr_en) begin
            if (hit_refv) begin
                reference_voltage_control <= pwdata & REFV_MASK;
            end
            if (hit_mask) begin
                irq_mask <= pwdata[1:0];
            end
            if (hit_route) begin
                trig_route <= pwdata[1:0];
            end
        end
    end

    // interrupt: flag gated by per-comparator enable and mask
    assign comparator_irq = |(irq_flag & irq_enable & irq_mask);

    // read mux; unmapped and reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl0) begin
            rd_mux = ctrl_word[0];
        end else if (hit_ctrl1) begin
            rd_mux = ctrl_word[1];
        end else if (hit_status) begin
            rd_mux[`DCC_STAT_FLAG_LO +: 2] = irq_flag;
            rd_mux[`DCC_STAT_OUT_LO +: 2]  = out_level;
        end else if (hit_refv) begin
            rd_mux = reference_voltage_control;
        end else if (hit_mask) begin
            rd_mux[1:0] = irq_mask;
        end else if (hit_route) begin
            rd_mux[1:0] = trig_route;
        end
    end

    // read data captured in the setup phase, so it comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= rd_mux;
        end
    end

    // checks on register writes, flags and trigger pulses
    property p_ctrl1_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl1 |=> ctrl_word[1] == ($past(pwdata) & `DCC_CTRL_MASK);
    endproperty
    a_ctrl1_write: assert property (p_ctrl1_write) else $error("ctrl1 write lost");

    property p_pos_sel;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl0 |=> comparator_cfg[0].positive_input_select == $past(pwdata[30:29]);
    endproperty
    a_pos_sel: assert property (p_pos_sel) else $error("positive select wrong");

    property p_enable_bit;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl0 |=> comparator_cfg[0].comparator_enable == $past(pwdata[0]);
    endproperty
    a_enable_bit: assert property (p_enable_bit) else $error("enable bit wrong");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        access_ph && !pwrite && (hit_ctrl0 || hit_ctrl1) |-> (prdata & ~`DCC_CTRL_MASK) == 32'h0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit reads one");

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        out_change[0] |=> irq_flag[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag not set on change");

    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_status && pwdata[0] && !out_change[0] |=> !irq_flag[0];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_flag_keep;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_status && !pwdata[1] && irq_flag[1] |=> irq_flag[1];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("flag lost on zero write");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        comparator_irq |-> |(irq_flag & irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enabled flag");

    property p_rise_trig;
        @(posedge pclk) disable iff (!presetn)
        edge_ev[0].rise && comparator_cfg[0].rising_trigger_enable && trig_route[0]
        |=> trigger_rise[0];
    endproperty
    a_rise_trig: assert property (p_rise_trig) else $error("rising trigger missing");

    property p_fall_off;
        @(posedge pclk) disable iff (!presetn)
        !comparator_cfg[0].falling_trigger_enable |=> !trigger_fall[0];
    endproperty
    a_fall_off: assert property (p_fall_off) else $error("falling trigger while off");

    property p_route_off;
        @(posedge pclk) disable iff (!presetn)
        !trig_route[1] |=> !trigger_rise[1] && !trigger_fall[1];
    endproperty
    a_route_off: assert property (p_route_off) else $error("trigger without route");

    property p_refv_write;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_refv |=> reference_voltage_control == ($past(pwdata) & REFV_MASK);
    endproperty
    a_refv_write: assert property (p_refv_write) else $error("reference write lost");

    property p_status_out;
        @(posedge pclk) disable iff (!presetn)
        access_ph && !pwrite && hit_status |-> prdata[`DCC_STAT_OUT_LO +: 2] == $past(out_level);
    endproperty
    a_status_out: assert property (p_status_out) else $error("output bits read wrong");

    property p_neg_sel;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl0 |=> comparator_cfg[0].negative_source_select == $past(pwdata[4]);
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("negative select wrong");

    property p_hys_bit;
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_ctrl0 |=> comparator_cfg[0].hysteresis_enable == $past(pwdata[2]);
    endproperty
    a_hys_bit: assert property (p_hys_bit) else $error("hysteresis bit wrong");

    property p_fall_trig;
        @(posedge pclk) disable iff (!presetn)
        edge_ev[1].fall && comparator_cfg[1].falling_trigger_enable && trig_route[1]
        |=> trigger_fall[1];
    endproperty
    a_fall_trig: assert property (p_fall_trig) else $error("falling trigger missing");

    property p_trig_pulse;
        @(posedge pclk) disable iff (!presetn)
        trigger_rise[0] |=> !trigger_rise[0];
    endproperty
    a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than a pulse");

    property p_settle_quiet;
        @(posedge pclk) disable iff (!presetn)
        !out_settled[1] |-> !edge_ev[1].rise && !edge_ev[1].fall;
    endproperty
    a_settle_quiet: assert property (p_settle_quiet) else $error("edge while settling");

    c_flag: cover property (@(posedge pclk) disable iff (!presetn) out_change[0] ##1 irq_flag[0]);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(comparator_irq));
    c_trig: cover property (@(posedge pclk) disable iff (!presetn) trigger_rise[0]);
    c_clear: cover property (@(posedge pclk) disable iff (!presetn)
        irq_flag[0] && wr_en && hit_status && pwdata[0]);

endmodule

// ==== inc/dcc_pkg.sv ====
// types shared by the comparator bank modules
package dcc_pkg;

    // decoded control word of one comparator
    typedef struct packed {
        logic [1:0] positive_input_select;
        logic       falling_trigger_enable;
        logic       rising_trigger_enable;
        logic       negative_source_select;
        logic       hysteresis_enable;
        logic       comparator_irq_enable;
        logic       comparator_enable;
    } dcc_ctrl_type;

    // one-cycle edge events of a sampled comparator output
    typedef struct packed {
        logic rise;
        logic fall;
    } dcc_edge_type;

endpackage

// ==== inc/dcc_regs.svh ====
// register offsets, field positions, reset values and timing counts of the comparator bank
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

// byte offsets from the comparator block base
`define DCC_OFF_CTRL0      12'h000
`define DCC_OFF_CTRL1      12'h004
`define DCC_OFF_STATUS     12'h008
`define DCC_OFF_REFV       12'h00c
`define DCC_OFF_IRQ_MASK   12'h010
`define DCC_OFF_TRIG_ROUTE 12'h014

// control word fields
`define DCC_POS_SEL_HI     30
`define DCC_POS_SEL_LO     29
`define DCC_FALL_BIT       9
`define DCC_RISE_BIT       8
`define DCC_NEG_BIT        4
`define DCC_HYS_BIT        2
`define DCC_IE_BIT         1
`define DCC_EN_BIT         0
`define DCC_CTRL_MASK      32'h6000_0317

// status word fields
`define DCC_STAT_FLAG_LO   0
`define DCC_STAT_OUT_LO    2

// reset values and reference write mask
`define DCC_CTRL_RST       32'h0000_0000
`define DCC_REFV_RST       32'h0000_0000
`define DCC_REFV_MASK      32'h0000_008f
`define DCC_FLAG_RST       2'h0
`define DCC_MASK_RST       2'h3
`define DCC_ROUTE_RST      2'h0

// settling time after enable, as a least time rounded up
`define DCC_SETTLE_NS      2000
`define DCC_CLK_NS         10
`define DCC_SETTLE_CYC     ((`DCC_SETTLE_NS + `DCC_CLK_NS - 1) / `DCC_CLK_NS)

`endif

// ==== test/dcc_bench.sv ====
// self-checking bench of the comparator control bank
`timescale 1ns/1ns
`include "dcc_regs.svh"

module dual_comparator_control_regs_bench;
    import dcc_pkg::*;

    localparam int unsigned SETTLE = 2; // short settling keeps the run brief

    logic               pclk;
    logic               presetn;
    logic               psel;
    logic               penable;
    logic               pwrite;
    logic [11:0]        paddr;
    logic [31:0]        pwdata;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
    logic [1:0]         comparator_raw;
    dcc_ctrl_type [1:0] comparator_cfg;
    logic [31:0]        reference_voltage_control;
    logic [1:0]         trigger_rise;
    logic [1:0]         trigger_fall;
    logic               comparator_irq;
    int                 failures;
    int                 check_count;
    logic [31:0]        rd;
    logic [31:0]        wd;
    logic [31:0]        fl;
    logic [31:0]        ob;
    logic [11:0]        ca;
    logic [11:0]        offs [6];
    logic [31:0]        rsts [6];

    dcc_top #(.SETTLE_CYCLES(SETTLE)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .comparator_raw(comparator_raw),
        .comparator_cfg(comparator_cfg),
        .reference_voltage_control(reference_voltage_control),
        .trigger_rise(trigger_rise), .trigger_fall(trigger_fall),
        .comparator_irq(comparator_irq)
    );

    // free-running 100 MHz clock
    always #5 pclk = ~pclk;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one apb transfer; read data taken at the edge that samples pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            failures++;
        end
        rd = prdata;
        check({31'h0, pslverr}, {31'h0, err});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_irq(input logic e);
        @(posedge pclk);
        #1;
        check({31'h0, comparator_irq}, {31'h0, e});
    endtask

    // moves one raw output and counts the trigger pulses that follow
    task automatic toggle(input int i, input logic v, input int er, input int ef);
        int r;
        int f;
        r = 0;
        f = 0;
        @(posedge pclk);
        comparator_raw[i] <= v;
        repeat (6) begin
            @(posedge pclk);
            #1;
            // an unknown counts as a pulse, so it cannot pass as quiet
            if (trigger_rise[i] !== 1'b0) r++;
            if (trigger_fall[i] !== 1'b0) f++;
        end
        check(r, er);
        check(f, ef);
    endtask

    function automatic dcc_ctrl_type exp_cfg(input logic [31:0] w);
        return {w[30:29], w[9], w[8], w[4], w[2], w[1], w[0]};
    endfunction

    // hang guard
    initial begin
        #200us;
        failures++;
        wrap_up();
    end

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        comparator_raw = 2'h0;
        failures = 0;
        check_count = 0;
        offs = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014};
        rsts = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h3, 32'h0};
        void'($urandom(32'hd85d));
        repeat (8) @(posedge pclk);
        check({16'h0, comparator_cfg}, 32'h0);
        presetn <= 1'b1;
        // reset values of every word
        for (int k = 0; k < 6; k++) begin
            apb(1'b0, offs[k], 32'h0, 1'b0);
            check(rd, rsts[k]);
        end
        // random control words, every positive input code on both comparators
        for (int k = 0; k < 8; k++) begin
            for (int i = 0; i < 2; i++) begin
                wd = $urandom();
                wd[30:29] = k[1:0];
                apb(1'b1, 12'(i * 4), wd, 1'b0);
                apb(1'b0, 12'(i * 4), 32'h0, 1'b0);
                check(rd, wd & 32'h6000_0317);
                check({24'h0, comparator_cfg[i]}, {24'h0, exp_cfg(wd)});
            end
        end
        wd = $urandom();
        apb(1'b1, 12'h00c, wd, 1'b0);
        apb(1'b0, 12'h00c, 32'h0, 1'b0);
        check(rd, wd & 32'h0000_008f);
        check(reference_voltage_control, wd & 32'h0000_008f);
        apb(1'b1, 12'h000, 32'h0, 1'b0);
        apb(1'b1, 12'h004, 32'h0, 1'b0);
        apb(1'b1, 12'h008, 32'h3, 1'b0);
        // unmapped place refuses and reads zero
        apb(1'b1, 12'h018, $urandom(), 1'b1);
        apb(1'b0, 12'h018, 32'h0, 1'b1);
        check(rd, 32'h0);
        // comparator path, each comparator in turn
        for (int i = 0; i < 2; i++) begin
            fl = 32'h1 << i;
            ob = 32'h4 << i;
            ca = 12'(i * 4);
            apb(1'b1, 12'h014, 32'h3, 1'b0);
            toggle(i, 1'b1, 0, 0);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, 32'h0);
            // enable with raw already high: no edge at end of settling
            apb(1'b1, ca, 32'h0000_0303, 1'b0);
            repeat (SETTLE + 4) @(posedge pclk);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, ob);
            toggle(i, 1'b0, 0, 1);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, fl);
            chk_irq(1'b1);
            apb(1'b1, 12'h008, 32'h0, 1'b0);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, fl);
            apb(1'b1, 12'h008, fl, 1'b0);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, 32'h0);
            chk_irq(1'b0);
            // rising only, interrupt off: flag still set, line quiet
            apb(1'b1, ca, 32'h0000_0101, 1'b0);
            toggle(i, 1'b1, 1, 0);
            apb(1'b0, 12'h008, 32'h0, 1'b0);
            check(rd, fl | ob);
            chk_irq(1'b0);
            // trigger not routed: edge enables have no effect
            apb(1'b1, ca, 32'h0000_0303, 1'b0);
            apb(1'b1, 12'h014, 32'h0, 1'b0);
            toggle(i, 1'b0, 0, 0);
            chk_irq(1'b1);
            apb(1'b1, 12'h010, 32'h3 ^ fl, 1'b0);
            chk_irq(1'b0);
            apb(1'b1, 12'h010, 32'h3, 1'b0);
            apb(1'b1, 12'h008, 32'h3, 1'b0);
            apb(1'b1, ca, 32'h0, 1'b0);
        end
        wrap_up();
    end
endmodule
